// ### rtl/adcp_pkg.sv
`default_nettype none
package adcp_pkg;

    // Result layout
    localparam int MAG_W = 12;
    localparam int HI_MAG_LSB = 8;
    localparam int HI_BYTE_W = 6;
    localparam int LO_BYTE_W = 8;

    // Reset values
    localparam logic [MAG_W-1:0] MAG_RST = 12'h000;
    localparam logic PIN_IDLE_LVL = 1'b1;

    typedef struct packed {
        logic over_range;
        logic polarity_flag;
        logic [MAG_W-1:0] magnitude;
    } adcp_result_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ENTER = 3'b001,
        ST_HI_LOAD = 3'b010,
        ST_HI_HOLD = 3'b011,
        ST_LO_LOAD = 3'b100,
        ST_LO_HOLD = 3'b101
    } adcp_state_e;

    // Control pins of the port; all active low
    typedef struct packed {
        logic ce_load_n;
        logic upper_byte_enable_n;
        logic lower_byte_enable_n;
    } adcp_ctl_s;

endpackage
`default_nettype wire

// ### rtl/adcp_output_port.sv
// Behaviour
// - CE low: each byte follows own enable
// - Both enables low: CE selects all 14 outputs
// - Status falls on each fresh result, also in handshake where the latch keeps the old one
// - Load strobe rising edge marks valid byte
// - Ready low holds byte and enable
// - Ready high advances to next byte
// - Mode high: every result taken in idle sent as handshake
// - Mode rising edge triggers one handshake
// - High byte first, low byte second
// - High byte: bits 9-12, polarity, over-range
// - Handshake turns control pins into outputs
// - Results during handshake are discarded
`timescale 1ns/10ps
`default_nettype none

module adcp_output_port #(
    parameter int MAG_W = adcp_pkg::MAG_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Conversion side
    input wire logic conv_active,
    input wire logic result_valid,
    input wire adcp_pkg::adcp_result_s result,
    // Mode and transfer ready
    input wire logic mode,
    input wire logic send_ready,
    // Control pins, two-way
    input wire adcp_pkg::adcp_ctl_s ctl_sense,
    output var adcp_pkg::adcp_ctl_s ctl_drive,
    output logic ctl_oe,
    // Result pins
    output logic [adcp_pkg::HI_BYTE_W-1:0] hi_byte_data,
    output logic hi_byte_oe,
    output logic [adcp_pkg::LO_BYTE_W-1:0] lo_byte_data,
    output logic lo_byte_oe,
    // Conversion status
    output logic status
);

    generate
        if (MAG_W != 12)
        begin : g_bad_width
            $error("adcp_output_port supports a 12-bit magnitude only");
        end
    endgenerate

    typedef struct packed {
        adcp_pkg::adcp_state_e fsm;
        logic mode_d;
        adcp_pkg::adcp_result_s latch;
        logic status;
        adcp_pkg::adcp_ctl_s ctl;
        logic ctl_oe;
        logic hi_oe;
        logic lo_oe;
    } adcp_port_state_s;

    adcp_port_state_s st_r;
    adcp_port_state_s st_nxt;

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.mode_d = mode;
        // Status drops on the edge that samples result_valid, whether or not that edge writes the latch
        st_nxt.status = conv_active && !result_valid;
        unique case (st_r.fsm)
            adcp_pkg::ST_IDLE:
            begin
                // Latch is written only here, so results in handshake are lost
                if (result_valid)
                begin
                    st_nxt.latch = result;
                end
                if ((mode && result_valid) || (mode && !st_r.mode_d))
                begin
                    st_nxt.fsm = adcp_pkg::ST_ENTER;
                end
            end
            adcp_pkg::ST_ENTER:
            begin
                if (send_ready)
                begin
                    st_nxt.fsm = adcp_pkg::ST_HI_LOAD;
                end
            end
            adcp_pkg::ST_HI_LOAD:
            begin
                st_nxt.fsm = adcp_pkg::ST_HI_HOLD;
            end
            adcp_pkg::ST_HI_HOLD:
            begin
                if (send_ready)
                begin
                    st_nxt.fsm = adcp_pkg::ST_LO_LOAD;
                end
            end
            adcp_pkg::ST_LO_LOAD:
            begin
                st_nxt.fsm = adcp_pkg::ST_LO_HOLD;
            end
            adcp_pkg::ST_LO_HOLD:
            begin
                if (send_ready)
                begin
                    st_nxt.fsm = adcp_pkg::ST_IDLE;
                end
            end
            default:
            begin
                st_nxt.fsm = adcp_pkg::ST_IDLE;
            end
        endcase

        // Pin levels follow the next state so they leave flops in step with it
        st_nxt.ctl = '{adcp_pkg::PIN_IDLE_LVL, adcp_pkg::PIN_IDLE_LVL, adcp_pkg::PIN_IDLE_LVL};
        st_nxt.ctl_oe = (st_nxt.fsm != adcp_pkg::ST_IDLE);
        st_nxt.hi_oe = 1'b0;
        st_nxt.lo_oe = 1'b0;
        unique case (st_nxt.fsm)
            adcp_pkg::ST_IDLE:
            begin
                // Direct mode; released otherwise so converters can share a bus
                st_nxt.hi_oe = !ctl_sense.ce_load_n && !ctl_sense.upper_byte_enable_n;
                st_nxt.lo_oe = !ctl_sense.ce_load_n && !ctl_sense.lower_byte_enable_n;
            end
            adcp_pkg::ST_ENTER:
            begin
                st_nxt.hi_oe = 1'b0;
            end
            adcp_pkg::ST_HI_LOAD:
            begin
                st_nxt.ctl.ce_load_n = 1'b0;
                st_nxt.ctl.upper_byte_enable_n = 1'b0;
                st_nxt.hi_oe = 1'b1;
            end
            adcp_pkg::ST_HI_HOLD:
            begin
                st_nxt.ctl.upper_byte_enable_n = 1'b0;
                st_nxt.hi_oe = 1'b1;
            end
            adcp_pkg::ST_LO_LOAD:
            begin
                st_nxt.ctl.ce_load_n = 1'b0;
                st_nxt.ctl.lower_byte_enable_n = 1'b0;
                st_nxt.lo_oe = 1'b1;
            end
            adcp_pkg::ST_LO_HOLD:
            begin
                st_nxt.ctl.lower_byte_enable_n = 1'b0;
                st_nxt.lo_oe = 1'b1;
            end
            default:
            begin
                st_nxt.lo_oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_r <= '{adcp_pkg::ST_IDLE, 1'b0,
                      '{1'b0, 1'b0, adcp_pkg::MAG_RST}, 1'b0,
                      '{adcp_pkg::PIN_IDLE_LVL, adcp_pkg::PIN_IDLE_LVL, adcp_pkg::PIN_IDLE_LVL},
                      1'b0, 1'b0, 1'b0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data pins come straight from the result latch
    assign hi_byte_data = {st_r.latch.over_range, st_r.latch.polarity_flag,
                           st_r.latch.magnitude[MAG_W-1:adcp_pkg::HI_MAG_LSB]};
    assign lo_byte_data = st_r.latch.magnitude[adcp_pkg::LO_BYTE_W-1:0];
    assign hi_byte_oe = st_r.hi_oe;
    assign lo_byte_oe = st_r.lo_oe;
    assign ctl_drive = st_r.ctl;
    assign ctl_oe = st_r.ctl_oe;
    assign status = st_r.status;

    ////////////////////////////////////////////////////////////////////////////
    a_direct_upper_byte: assert property (@(posedge core_clk) disable iff (!reset_n)
        (st_r.fsm == adcp_pkg::ST_IDLE && !mode && !ctl_sense.ce_load_n && !ctl_sense.upper_byte_enable_n)
        |=> hi_byte_oe && !ctl_oe)
        else $error("upper byte not enabled in direct mode");

    a_direct_chip_select: assert property (@(posedge core_clk) disable iff (!reset_n)
        (st_r.fsm == adcp_pkg::ST_IDLE && !mode && !ctl_sense.ce_load_n
         && !ctl_sense.upper_byte_enable_n && !ctl_sense.lower_byte_enable_n)
        |=> hi_byte_oe && lo_byte_oe)
        else $error("chip select did not enable all outputs");

    a_idle_hiz: assert property (@(posedge core_clk) disable iff (!reset_n)
        (st_r.fsm == adcp_pkg::ST_IDLE && ctl_sense.ce_load_n) |=> !hi_byte_oe && !lo_byte_oe)
        else $error("outputs driven while not enabled");

    a_status_fall_latch: assert property (@(posedge core_clk) disable iff (!reset_n)
        $fell(status) |-> $past(result_valid))
        else $error("status fell without a fresh result");

    a_load_strobe_byte: assert property (@(posedge core_clk) disable iff (!reset_n)
        ($rose(ctl_drive.ce_load_n) && ctl_oe)
        |-> (hi_byte_oe && !ctl_drive.upper_byte_enable_n) || (lo_byte_oe && !ctl_drive.lower_byte_enable_n))
        else $error("load strobe edge without valid byte");

    a_hold_not_ready: assert property (@(posedge core_clk) disable iff (!reset_n)
        (st_r.fsm == adcp_pkg::ST_HI_HOLD && !send_ready)
        |=> st_r.fsm == adcp_pkg::ST_HI_HOLD && hi_byte_oe && !ctl_drive.upper_byte_enable_n)
        else $error("high byte not held while ready low");

    a_advance_on_ready: assert property (@(posedge core_clk) disable iff (!reset_n)
        (st_r.fsm == adcp_pkg::ST_HI_HOLD && send_ready)
        |=> !hi_byte_oe && lo_byte_oe && !ctl_drive.ce_load_n ##1 ctl_drive.ce_load_n)
        else $error("sequence did not advance to low byte");

    a_high_first: assert property (@(posedge core_clk) disable iff (!reset_n)
        $fell(ctl_drive.lower_byte_enable_n) |-> $past(st_r.fsm, 1) == adcp_pkg::ST_HI_HOLD)
        else $error("low byte sent before high byte");

    a_end_release: assert property (@(posedge core_clk) disable iff (!reset_n)
        (st_r.fsm == adcp_pkg::ST_LO_HOLD && send_ready) |=> !ctl_oe && ctl_drive.lower_byte_enable_n)
        else $error("pins not released after transfer");

    a_mode_edge_start: assert property (@(posedge core_clk) disable iff (!reset_n)
        (st_r.fsm == adcp_pkg::ST_IDLE && mode && !st_r.mode_d) |=> ctl_oe ##0 !hi_byte_oe)
        else $error("mode edge did not start handshake");

    a_every_result: assert property (@(posedge core_clk) disable iff (!reset_n)
        (st_r.fsm == adcp_pkg::ST_IDLE && mode && result_valid) |=> st_r.fsm == adcp_pkg::ST_ENTER)
        else $error("result not sent in handshake");

    a_discard_in_handshake: assert property (@(posedge core_clk) disable iff (!reset_n)
        (st_r.fsm != adcp_pkg::ST_IDLE) |=> $stable(st_r.latch))
        else $error("latch updated during handshake");

endmodule

`default_nettype wire

// ### sim/adcp_rx_model.sv
`timescale 1ns/10ps
`default_nettype none
module adcp_rx_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Port side
    input wire adcp_pkg::adcp_ctl_s ctl_drive,
    input wire logic ctl_oe,
    input wire logic [5:0] hi_byte_data,
    input wire logic [7:0] lo_byte_data,
    // Receiver side
    input wire logic [3:0] stall,
    output logic send_ready,
    output logic [5:0] got_hi,
    output logic [7:0] got_lo,
    output logic [3:0] n_bytes,
    output logic hi_first
);
    logic [3:0] cnt;
    logic strobe;
    assign strobe = ctl_oe && !ctl_drive.ce_load_n;
    // Buffer with a nonzero stall reports full while the strobe is still low, as a real one would
    assign send_ready = (cnt == 4'h0) && !(strobe && stall != 4'h0);
    always @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt <= 4'h0;
            n_bytes <= 4'h0;
            hi_first <= 1'b0;
        end
        else if (strobe)
        begin
            // Enables used as byte flags
            if (!ctl_drive.upper_byte_enable_n) got_hi <= hi_byte_data;
            if (!ctl_drive.lower_byte_enable_n) got_lo <= lo_byte_data;
            if (n_bytes == 4'h0) hi_first <= !ctl_drive.upper_byte_enable_n;
            n_bytes <= n_bytes + 4'h1;
            cnt <= stall;
        end
        else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
    end
endmodule
`default_nettype wire

// ### sim/adcp_output_port_bench.sv
`timescale 1ns/10ps
`default_nettype none
module adcp_output_port_bench;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic conv_active = 1'b0;
    logic result_valid = 1'b0;
    adcp_pkg::adcp_result_s result = '0;
    logic mode = 1'b0;
    logic [3:0] stall = 4'h0;
    adcp_pkg::adcp_ctl_s host_ctl = 3'b111;
    adcp_pkg::adcp_ctl_s ctl_sense, ctl_drive;
    logic send_ready, ctl_oe, hi_byte_oe, lo_byte_oe, status, hi_first;
    logic [5:0] hi_byte_data, got_hi;
    logic [7:0] lo_byte_data, got_lo;
    logic [3:0] n_bytes;
    int num_errors = 0;
    int n_compared = 0;

    always #50 core_clk = ~core_clk;
    // Device levels win once it owns the pins
    assign ctl_sense = ctl_oe ? ctl_drive : host_ctl;

    adcp_output_port dut (.core_clk, .reset_n, .conv_active, .result_valid, .result, .mode,
        .send_ready, .ctl_sense, .ctl_drive, .ctl_oe, .hi_byte_data, .hi_byte_oe,
        .lo_byte_data, .lo_byte_oe, .status);
    adcp_rx_model rx (.core_clk, .reset_n, .ctl_drive, .ctl_oe, .hi_byte_data, .lo_byte_data,
        .stall, .send_ready, .got_hi, .got_lo, .n_bytes, .hi_first);

////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic load(input logic [13:0] r);
        result = r;
        result_valid = 1'b1;
        @(negedge core_clk);
        result_valid = 1'b0;
    endtask

    task automatic wait_oe(input logic v);
        int i;
        for (i = 0; i < 100 && ctl_oe !== v; i++)
            @(negedge core_clk);
        check("ctl_oe", ctl_oe, v);
    endtask

////////////////////////////////////////////////////////////////////////////////
    task automatic t_direct();
        int k;
        // Software starts conversions from a port line
        conv_active = 1'b1;
        repeat (2) @(negedge core_clk);
        check("status busy", status, 1'b1);
        load(14'h2a5c);
        // Status was high at the first look; this later read falls in the one cycle it is low
        check("status", status, 1'b0);
        check("result", {hi_byte_data, lo_byte_data}, 14'h2a5c);
        for (k = 0; k < 8; k++)
        begin
            host_ctl = k[2:0];
            @(negedge core_clk);
            check("hi_oe", hi_byte_oe, !k[2] && !k[1]);
            check("lo_oe", lo_byte_oe, !k[2] && !k[0]);
        end
        host_ctl = 3'b111;
    endtask

    task automatic t_demand();
        int i;
        stall = 4'h5;
        mode = 1'b1;
        wait_oe(1'b1);
        for (i = 0; i < 20 && hi_byte_oe !== 1'b1; i++)
            @(negedge core_clk);
        // A result arriving mid-transfer must not disturb the bytes
        load(14'h1333);
        repeat (2) @(negedge core_clk);
        check("hold", {hi_byte_oe, ctl_drive.upper_byte_enable_n, lo_byte_oe}, 3'b100);
        wait_oe(1'b0);
        check("got hi", got_hi, 6'h2a);
        check("got lo", got_lo, 8'h5c);
        check("order", {hi_first, n_bytes}, 5'h12);
        check("kept", lo_byte_data, 8'h5c);
    endtask

    task automatic t_held();
        stall = 4'h0;
        repeat (3) @(negedge core_clk);
        check("no start", ctl_oe, 1'b0);
        load(14'h0fa1);
        wait_oe(1'b1);
        wait_oe(1'b0);
        check("held", {got_hi, got_lo, n_bytes}, 18'h0fa14);
        mode = 1'b0;
    endtask

////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (10) @(negedge core_clk);
        reset_n = 1'b1;
        @(negedge core_clk);
        t_direct();
        t_demand();
        t_held();
        summarize();
    end

    initial
    begin
        #1000000;
        num_errors++;
        summarize();
    end
endmodule
`default_nettype wire
